/* File: src/dtc_timer_top.v */
// Dual timer/counter with external interrupt flags, on the special register space.
`include "dtc_defines.vh"

// Contract
// - Registers live in 80-FFh, direct access only
// - Control register supports single-bit writes
// - Unimplemented addresses and bits read one
// - Timer 1 overflow flag, acked, software writable
// - Timer 0 overflow flag, acked, software writable
// - Run bits switch each timer on/off
// - External flags: edge cleared on ack, level follows
// - Type bit: falling edge or low level
// - Gate bit requires pin high to count
// - Count source: internal tick or pin falls
// - Mode 0: 8-bit with 5-bit prescale
// - Mode 1: full 16-bit counter
// - Mode 2: low byte reloads from high
// - Mode 3 splits timer 0 in two
// - Timer 1 in mode 3 holds value
// - Count bytes individually read and written
// - Idle keeps timers and flags running
// - Power-down freezes all counting; flags change only by ack or write
// - Internal tick is clock/4 or clock/12
module dtc_timer_top (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Byte access to the special register space
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata_q,
  // Bit access to the bit-addressable space
  input  wire [7:0] bit_addr,
  input  wire       bit_wr,
  input  wire       bit_rd,
  input  wire       bit_wdata,
  output reg        bit_rdata_q,
  // Pins
  input  wire       ext_irq_pin_zero,
  input  wire       ext_irq_pin_one,
  input  wire       t0_count_pin,
  input  wire       t1_count_pin,
  // Clock selection and power state
  input  wire       timer0_prescale_sel,
  input  wire       timer1_prescale_sel,
  input  wire       power_down_request,
  // Interrupt service acknowledges
  input  wire       timer0_irq_ack,
  input  wire       timer1_irq_ack,
  input  wire       ext0_irq_ack,
  input  wire       ext1_irq_ack,
  // Flags toward the interrupt controller
  output reg        timer0_overflow_flag,
  output reg        timer1_overflow_flag,
  output reg        ext0_event_flag,
  output reg        ext1_event_flag
);

  // --------------------------------------------------------------------------
  // Step function shared by both timers
  // --------------------------------------------------------------------------
  // Returns {overflow, high, low}; mode 3 is handled by the caller.
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [13:0] pre;
    reg   [16:0] full;
    reg   [8:0]  low;
    begin
      pre  = {1'b0, hi, lo[4:0]} + 14'h0001;
      full = {1'b0, hi, lo} + 17'h00001;
      low  = {1'b0, lo} + 9'h001;
      case (mode)
        `DTC_MODE_PRESCALE: dtc_step = {pre[13], pre[12:5], lo[7:5], pre[4:0]};
        `DTC_MODE_FULL:     dtc_step = full;
        `DTC_MODE_RELOAD:   dtc_step = {low[8], hi, (low[8] ? hi : low[7:0])};
        default:            dtc_step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0] timer_irq_control_q;
  reg  [7:0] timer_irq_control_d;
  reg  [7:0] timer_mode_config_q;
  reg  [7:0] tl0_q;
  reg  [7:0] tl0_d;
  reg  [7:0] th0_q;
  reg  [7:0] th0_d;
  reg  [7:0] tl1_q;
  reg  [7:0] tl1_d;
  reg  [7:0] th1_q;
  reg  [7:0] th1_d;
  reg  [3:0] sync1_q;
  reg  [3:0] sync2_q;
  reg  [3:0] prev_q;
  reg        ovf0;
  reg        ovf1;
  reg        ovf_split;
  reg  [8:0] split_lo;
  reg  [8:0] split_hi;
  reg  [7:0] sw_mask;
  reg  [7:0] sw_val;
  reg  [7:0] rd_mux;
  wire       tick0;
  wire       tick1;
  wire [3:0] falls;
  wire       ext_irq_pin_zero_s;
  wire       ext_irq_pin_one_s;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire       run0;
  wire       run1;
  wire       inc0;
  wire       inc1;
  wire       freeze;
  wire [16:0] step0;
  wire [16:0] step1;
  wire       timer_irq_control_bit_hit;

  // --------------------------------------------------------------------------
  // Pin synchronisers; bit order {t1 pin, t0 pin, ext_irq_pin_one, ext_irq_pin_zero}
  // --------------------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      prev_q  <= 4'hF;
    end else begin
      sync1_q <= {t1_count_pin, t0_count_pin, ext_irq_pin_one, ext_irq_pin_zero};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign falls  = prev_q & ~sync2_q;
  assign ext_irq_pin_zero_s = sync2_q[0];
  assign ext_irq_pin_one_s = sync2_q[1];

  // --------------------------------------------------------------------------
  // Tick generation and count enables
  // --------------------------------------------------------------------------
  // Idle has no input here: the block runs on the ungated clock.
  assign freeze = power_down_request;

  dtc_prescale u_pre0 (
    .clock    (clock),
    .rst      (rst),
    .sel_fast (timer0_prescale_sel),
    .freeze   (freeze),
    .tick_q   (tick0)
  );

  dtc_prescale u_pre1 (
    .clock    (clock),
    .rst      (rst),
    .sel_fast (timer1_prescale_sel),
    .freeze   (freeze),
    .tick_q   (tick1)
  );

  assign mode0 = timer_mode_config_q[`DTC_MODE0_HI:`DTC_MODE0_LO];
  assign mode1 = timer_mode_config_q[`DTC_MODE1_HI:`DTC_MODE1_LO];
  assign run0  = timer_irq_control_q[`DTC_RUN0] & (~timer_mode_config_q[`DTC_GATE0] | ext_irq_pin_zero_s);
  assign run1  = timer_irq_control_q[`DTC_RUN1] & (~timer_mode_config_q[`DTC_GATE1] | ext_irq_pin_one_s);
  assign inc0  = run0 & (timer_mode_config_q[`DTC_CT0] ? falls[2] : tick0);
  assign inc1  = run1 & (timer_mode_config_q[`DTC_CT1] ? falls[3] : tick1);
  assign step0 = dtc_step(mode0, th0_q, tl0_q);
  assign step1 = dtc_step(mode1, th1_q, tl1_q);

  // --------------------------------------------------------------------------
  // Counter next state
  // --------------------------------------------------------------------------
  // A software write to a count byte wins over a count in the same cycle.
  always @* begin
    tl0_d     = tl0_q;
    th0_d     = th0_q;
    tl1_d     = tl1_q;
    th1_d     = th1_q;
    ovf0      = 1'b0;
    ovf1      = 1'b0;
    ovf_split = 1'b0;
    split_lo  = {1'b0, tl0_q} + 9'h001;
    split_hi  = {1'b0, th0_q} + 9'h001;
    if (!freeze) begin
      if (mode0 == `DTC_MODE_SPLIT) begin
        if (inc0) begin
          tl0_d = split_lo[7:0];
          ovf0  = split_lo[8];
        end
        // The high half is a timer only, enabled by the timer 1 run bit.
        if (timer_irq_control_q[`DTC_RUN1] & tick0) begin
          th0_d     = split_hi[7:0];
          ovf_split = split_hi[8];
        end
      end else if (inc0) begin
        {ovf0, th0_d, tl0_d} = step0;
      end
      if ((mode1 != `DTC_MODE_SPLIT) && inc1) begin
        {ovf1, th1_d, tl1_d} = step1;
      end
    end
    if (sfr_wr) begin
      case (sfr_addr)
        `DTC_ADDR_T0_LOW:  tl0_d = sfr_wdata;
        `DTC_ADDR_T1_LOW:  tl1_d = sfr_wdata;
        `DTC_ADDR_T0_HIGH: th0_d = sfr_wdata;
        `DTC_ADDR_T1_HIGH: th1_d = sfr_wdata;
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Control register next state
  // --------------------------------------------------------------------------
  assign timer_irq_control_bit_hit = (bit_addr[7:3] == `DTC_ADDR_IRQ_CTRL >> 3);

  always @* begin
    sw_mask = 8'h00;
    sw_val  = 8'h00;
    if (sfr_wr && (sfr_addr == `DTC_ADDR_IRQ_CTRL)) begin
      sw_mask = 8'hFF;
      sw_val  = sfr_wdata;
    end else if (bit_wr && timer_irq_control_bit_hit) begin
      sw_mask = 8'h01 << bit_addr[2:0];
      sw_val  = {8{bit_wdata}};
    end
    timer_irq_control_d = (timer_irq_control_q & ~sw_mask) | (sw_val & sw_mask);
    // Acknowledge clears first so that a coincident hardware set wins.
    if (timer1_irq_ack) begin
      timer_irq_control_d[`DTC_OVF1] = 1'b0;
    end
    if (timer0_irq_ack) begin
      timer_irq_control_d[`DTC_OVF0] = 1'b0;
    end
    if (mode0 == `DTC_MODE_SPLIT ? ovf_split : ovf1) begin
      timer_irq_control_d[`DTC_OVF1] = 1'b1;
    end
    if (ovf0) begin
      timer_irq_control_d[`DTC_OVF0] = 1'b1;
    end
    if (timer_irq_control_q[`DTC_EXT0_TYPE]) begin
      if (ext0_irq_ack) begin
        timer_irq_control_d[`DTC_EXT0_FLAG] = 1'b0;
      end
      if (falls[0] && !freeze) begin
        timer_irq_control_d[`DTC_EXT0_FLAG] = 1'b1;
      end
    end else if (!freeze) begin
      timer_irq_control_d[`DTC_EXT0_FLAG] = ~ext_irq_pin_zero_s;
    end
    if (timer_irq_control_q[`DTC_EXT1_TYPE]) begin
      if (ext1_irq_ack) begin
        timer_irq_control_d[`DTC_EXT1_FLAG] = 1'b0;
      end
      if (falls[1] && !freeze) begin
        timer_irq_control_d[`DTC_EXT1_FLAG] = 1'b1;
      end
    end else if (!freeze) begin
      timer_irq_control_d[`DTC_EXT1_FLAG] = ~ext_irq_pin_one_s;
    end
  end

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  always @* begin
    case (sfr_addr)
      `DTC_ADDR_IRQ_CTRL: rd_mux = timer_irq_control_q;
      `DTC_ADDR_MODE_CFG: rd_mux = timer_mode_config_q;
      `DTC_ADDR_T0_LOW:   rd_mux = tl0_q;
      `DTC_ADDR_T1_LOW:   rd_mux = tl1_q;
      `DTC_ADDR_T0_HIGH:  rd_mux = th0_q;
      `DTC_ADDR_T1_HIGH:  rd_mux = th1_q;
      default:            rd_mux = `DTC_UNIMPL_READ;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_irq_control_q               <= `DTC_RST_IRQ_CTRL;
      timer_mode_config_q               <= `DTC_RST_MODE_CFG;
      tl0_q                <= `DTC_RST_COUNT;
      th0_q                <= `DTC_RST_COUNT;
      tl1_q                <= `DTC_RST_COUNT;
      th1_q                <= `DTC_RST_COUNT;
      sfr_rdata_q          <= `DTC_UNIMPL_READ;
      bit_rdata_q          <= 1'b1;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
      ext0_event_flag      <= 1'b0;
      ext1_event_flag      <= 1'b0;
    end else begin
      timer_irq_control_q               <= timer_irq_control_d;
      tl0_q                <= tl0_d;
      th0_q                <= th0_d;
      tl1_q                <= tl1_d;
      th1_q                <= th1_d;
      timer0_overflow_flag <= timer_irq_control_d[`DTC_OVF0];
      timer1_overflow_flag <= timer_irq_control_d[`DTC_OVF1];
      ext0_event_flag      <= timer_irq_control_d[`DTC_EXT0_FLAG];
      ext1_event_flag      <= timer_irq_control_d[`DTC_EXT1_FLAG];
      if (sfr_wr && (sfr_addr == `DTC_ADDR_MODE_CFG)) begin
        timer_mode_config_q <= sfr_wdata;
      end
      if (sfr_rd) begin
        sfr_rdata_q <= rd_mux;
      end
      if (bit_rd) begin
        bit_rdata_q <= timer_irq_control_bit_hit ? timer_irq_control_q[bit_addr[2:0]] : 1'b1;
      end
    end
  end

endmodule // dtc_timer_top

/* File: common/dtc_defines.vh */
// Constants of the dual timer/counter block: addresses, fields, resets, timing.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ----------------------------------------------------------------------------
// Special register addresses
// ----------------------------------------------------------------------------
`define DTC_SPACE_BASE      8'h80
`define DTC_ADDR_IRQ_CTRL   8'h88
`define DTC_ADDR_MODE_CFG   8'h89
`define DTC_ADDR_T0_LOW     8'h8A
`define DTC_ADDR_T1_LOW     8'h8B
`define DTC_ADDR_T0_HIGH    8'h8C
`define DTC_ADDR_T1_HIGH    8'h8D
`define DTC_UNIMPL_READ     8'hFF

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DTC_OVF1            7
`define DTC_RUN1            6
`define DTC_OVF0            5
`define DTC_RUN0            4
`define DTC_EXT1_FLAG       3
`define DTC_EXT1_TYPE       2
`define DTC_EXT0_FLAG       1
`define DTC_EXT0_TYPE       0

// ----------------------------------------------------------------------------
// Mode register fields (per nibble: gate, count source, mode[1:0])
// ----------------------------------------------------------------------------
`define DTC_GATE1           7
`define DTC_CT1             6
`define DTC_MODE1_HI        5
`define DTC_MODE1_LO        4
`define DTC_GATE0           3
`define DTC_CT0             2
`define DTC_MODE0_HI        1
`define DTC_MODE0_LO        0

`define DTC_MODE_PRESCALE   2'h0
`define DTC_MODE_FULL       2'h1
`define DTC_MODE_RELOAD     2'h2
`define DTC_MODE_SPLIT      2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DTC_RST_IRQ_CTRL    8'h00
`define DTC_RST_MODE_CFG    8'h00
`define DTC_RST_COUNT       8'h00

// ----------------------------------------------------------------------------
// Internal tick divide ratios, in system clocks
// ----------------------------------------------------------------------------
`define DTC_DIV_FAST        4'h4
`define DTC_DIV_SLOW        4'hC

`endif

/* File: src/dtc_prescale.v */
// Internal tick generator: system clock divided by 4 or by 12.
`include "dtc_defines.vh"

module dtc_prescale (
  // Clock and reset
  input  wire clock,
  input  wire rst,
  // Control
  input  wire sel_fast,
  input  wire freeze,
  // Tick
  output reg  tick_q
);

  reg  [3:0] count_q;
  wire [3:0] limit;

  assign limit = sel_fast ? (`DTC_DIV_FAST - 4'h1) : (`DTC_DIV_SLOW - 4'h1);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= 4'h0;
      tick_q  <= 1'b0;
    end else if (freeze) begin
      tick_q  <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= 4'h0;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q + 4'h1;
      tick_q  <= 1'b0;
    end
  end

endmodule // dtc_prescale

/* File: tb/dtc_pin_model.sv */
// Pin model: drives the interrupt and count pins of the timer block.
module dtc_pin_model (
  // Clock
  input  wire logic clock,
  // Pins
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one,
  output logic      t0_count_pin,
  output logic      t1_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle high, as the synchronisers assume after reset
  initial begin
    ext_irq_pin_zero = 1'b1;
    ext_irq_pin_one  = 1'b1;
    t0_count_pin     = 1'b1;
    t1_count_pin     = 1'b1;
  end

  task set_int(input logic v0, input logic v1);
    @(posedge clock);
    ext_irq_pin_zero <= v0;
    ext_irq_pin_one  <= v1;
  endtask

  // Low phases of 4 clocks and high phases of 5 between falls, so every fall survives the sync
  task falls(input int n);
    repeat (n) begin
      @(posedge clock);
      t0_count_pin <= 1'b0;
      repeat (4) @(posedge clock);
      t0_count_pin <= 1'b1;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule // dtc_pin_model

/* File: tb/dtc_timer_top_monitor.sv */
// Checker of the timer block's register port and flags.
module dtc_timer_top_monitor (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Register access
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic [7:0] bit_addr,
  input wire logic       bit_wr,
  input wire logic       bit_rd,
  input wire logic       bit_rdata_q,
  // Power and acknowledges
  input wire logic       power_down_request,
  input wire logic       timer0_irq_ack,
  input wire logic       timer1_irq_ack,
  input wire logic       ext0_irq_ack,
  input wire logic       ext1_irq_ack,
  // Flags
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag,
  input wire logic       ext0_event_flag,
  input wire logic       ext1_event_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_unimpl_read;
    sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8D) |=> sfr_rdata_q == 8'hFF;
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("unmapped read not FF");

  property p_bit_unimpl;
    bit_rd && bit_addr[7:3] != 5'h11 |=> bit_rdata_q;
  endproperty
  a_bit_unimpl: assert property (p_bit_unimpl) else $error("unmapped bit not 1");

  property p_mode_rw;
    sfr_wr && sfr_addr == 8'h89 ##1 sfr_rd && sfr_addr == 8'h89
      |=> sfr_rdata_q == $past(sfr_wdata, 2);
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("mode readback wrong");

  property p_flag_mirror;
    sfr_rd && sfr_addr == 8'h88 |=>
      {sfr_rdata_q[7], sfr_rdata_q[5], sfr_rdata_q[3], sfr_rdata_q[1]} ==
      $past({timer1_overflow_flag, timer0_overflow_flag, ext1_event_flag, ext0_event_flag});
  endproperty
  a_flag_mirror: assert property (p_flag_mirror) else $error("flags differ");

  property p_bit_flag;
    bit_rd && bit_addr == 8'h8D |=> bit_rdata_q == $past(timer0_overflow_flag);
  endproperty
  a_bit_flag: assert property (p_bit_flag) else $error("bit read wrong");

  property p_rdata_hold;
    !sfr_rd |=> $stable(sfr_rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_bit_hold;
    !bit_rd |=> $stable(bit_rdata_q);
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("bit data moved");

  property p_pd_freeze;
    power_down_request && !sfr_wr && !bit_wr &&
      !(timer0_irq_ack || timer1_irq_ack || ext0_irq_ack || ext1_irq_ack)
      |=> $stable({timer0_overflow_flag, timer1_overflow_flag, ext0_event_flag, ext1_event_flag});
  endproperty
  a_pd_freeze: assert property (p_pd_freeze) else $error("flag moved in power-down");
endmodule // dtc_timer_top_monitor

bind dtc_timer_top dtc_timer_top_monitor u_dtc_timer_top_monitor (
  .clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .bit_addr(bit_addr),
  .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_rdata_q(bit_rdata_q),
  .power_down_request(power_down_request), .timer0_irq_ack(timer0_irq_ack),
  .timer1_irq_ack(timer1_irq_ack), .ext0_irq_ack(ext0_irq_ack),
  .ext1_irq_ack(ext1_irq_ack), .timer0_overflow_flag(timer0_overflow_flag),
  .timer1_overflow_flag(timer1_overflow_flag), .ext0_event_flag(ext0_event_flag),
  .ext1_event_flag(ext1_event_flag));

/* File: tb/tb_dtc_timer_top.sv */
// Testbench of the dual timer/counter block.
module tb_dtc_timer_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, bit_rdata_q, pd, b;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, bit_addr, d, e;
  logic [3:0] ack;
  logic [1:0] psel;
  wire  [3:0] fl;
  wire        p0, p1, c0, c1;
  int         bad_count, samples_checked, cyc, i, m;

  dtc_pin_model u_dtc_pin_model (.clock(clock), .ext_irq_pin_zero(p0),
    .ext_irq_pin_one(p1), .t0_count_pin(c0), .t1_count_pin(c1));

  dtc_timer_top u_dtc_timer_top (.clock(clock), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata_q(bit_rdata_q), .ext_irq_pin_zero(p0), .ext_irq_pin_one(p1),
    .t0_count_pin(c0), .t1_count_pin(c1), .timer0_prescale_sel(psel[0]),
    .timer1_prescale_sel(psel[1]), .power_down_request(pd), .timer0_irq_ack(ack[0]),
    .timer1_irq_ack(ack[1]), .ext0_irq_ack(ack[2]), .ext1_irq_ack(ack[3]),
    .timer0_overflow_flag(fl[0]), .timer1_overflow_flag(fl[1]),
    .ext0_event_flag(fl[2]), .ext1_event_flag(fl[3]));

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  // Strobes stay as set until the next call, so wr and bw end with an idle cycle
  task go(input logic [3:0] s, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    {sfr_wr, sfr_rd, bit_wr, bit_rd} <= s;
    sfr_addr  <= a;
    bit_addr  <= a;
    sfr_wdata <= v;
    bit_wdata <= v[0];
    #1;
  endtask
  task idle(input int n);
    repeat (n) go(4'h0, 8'h00, 8'h00);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    go(4'h8, a, v);
    idle(1);
  endtask
  task bw(input logic [7:0] a, input logic v);
    go(4'h2, a, {7'h00, v});
    idle(1);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    go(4'h4, a, 8'h00);
    idle(1);
    v = sfr_rdata_q;
  endtask
  task brd(input logic [7:0] a, output logic v);
    go(4'h1, a, 8'h00);
    idle(1);
    v = bit_rdata_q;
  endtask
  task ackp(input int k);
    @(posedge clock);
    ack[k] <= 1'b1;
    @(posedge clock);
    ack[k] <= 1'b0;
    #1;
  endtask
  task chk8(input string n, input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task chk1(input string n, input logic x, input logic g);
    chk8(n, {7'h00, x}, {7'h00, g});
  endtask
  task wf(input int k, input logic v);
    for (int n = 0; n < 300 && fl[k] !== v; n++) idle(1);
    chk1("flag", v, fl[k]);
  endtask
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude;
    end
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, pd} = 6'h00;
    {sfr_addr, sfr_wdata, bit_addr} = 24'h000000;
    ack = 4'h0;
    psel = 2'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(8'h88 + i, d);
      chk8("reset", (i < 6) ? 8'h00 : 8'hFF, d);
    end
    rd(8'h80, d);
    chk8("unmapped", 8'hFF, d);
    brd(8'h87, b);
    chk1("bit unmapped", 1'b1, b);
    $display("test reset done");
    for (i = 0; i < 4; i++) wr(8'h8A + i, 8'h11 * (i + 1));
    for (i = 0; i < 4; i++) begin
      rd(8'h8A + i, d);
      chk8("count byte", 8'h11 * (i + 1), d);
    end
    go(4'h8, 8'h89, 8'hA5);
    rd(8'h89, d);
    chk8("mode", 8'hA5, d);
    $display("test bytes done");
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      psel <= {i[0], i[0]};
      wr(8'h89, 8'h01);
      wr(8'h8A, 8'h00);
      wr(8'h8C, 8'h00);
      bw(8'h8C, 1'b1);
      idle(120);
      bw(8'h8C, 1'b0);
      rd(8'h8A, d);
      m = i ? 29 : 9;
      chk1("rate", 1'b1, d >= m && d <= m + 2);
    end
    $display("test rate done");
    for (m = 0; m < 2; m++) begin
      wr(8'h88, 8'h00);
      wr(8'h89, m);
      wr(8'h8C, 8'hFF);
      wr(8'h8A, 8'hFE);
      bw(8'h8C, 1'b1);
      wf(0, 1'b1);
      bw(8'h8C, 1'b0);
      rd(8'h8C, d);
      chk8("high byte", 8'h00, d);
      rd(8'h8A, d);
      chk8("low top", m ? 8'h00 : 8'h07, {5'h00, d[7:5]});
      brd(8'h8D, b);
      chk1("bit flag", 1'b1, b);
      ackp(0);
      chk1("ack", 1'b0, fl[0]);
      bw(8'h8D, 1'b1);
      chk1("sw set", 1'b1, fl[0]);
    end
    $display("test wrap done");
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8B, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'hFE);
    bw(8'h8E, 1'b1);
    wf(1, 1'b1);
    bw(8'h8E, 1'b0);
    rd(8'h8A, d);
    chk8("split low", 8'h00, d);
    rd(8'h8B, d);
    chk8("t1 held", 8'h05, d);
    ackp(1);
    chk1("ack1", 1'b0, fl[1]);
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    bw(8'h8E, 1'b1);
    wf(1, 1'b1);
    bw(8'h8E, 1'b0);
    rd(8'h8B, d);
    chk8("reload", 8'h0F, {4'h0, d[7:4]});
    $display("test split reload done");
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'h00);
    bw(8'h8C, 1'b1);
    u_dtc_pin_model.set_int(1'b0, 1'b1);
    u_dtc_pin_model.falls(3);
    idle(5);
    rd(8'h8A, d);
    chk8("gated", 8'h00, d);
    u_dtc_pin_model.set_int(1'b1, 1'b1);
    u_dtc_pin_model.falls(5);
    idle(5);
    rd(8'h8A, d);
    chk8("pin count", 8'h05, d);
    bw(8'h8C, 1'b0);
    $display("test gate done");
    for (i = 0; i < 2; i++) begin
      bw(8'h88 + 2 * i, 1'b1);
      u_dtc_pin_model.set_int(i != 0, i == 0);
      wf(2 + i, 1'b1);
      u_dtc_pin_model.set_int(1'b1, 1'b1);
      idle(6);
      chk1("edge latch", 1'b1, fl[2 + i]);
      ackp(2 + i);
      wf(2 + i, 1'b0);
      bw(8'h88 + 2 * i, 1'b0);
      u_dtc_pin_model.set_int(i != 0, i == 0);
      wf(2 + i, 1'b1);
      u_dtc_pin_model.set_int(1'b1, 1'b1);
      wf(2 + i, 1'b0);
    end
    $display("test ext done");
    wr(8'h89, 8'h01);
    bw(8'h8C, 1'b1);
    @(posedge clock);
    pd <= 1'b1;
    idle(2);
    rd(8'h8A, d);
    idle(30);
    rd(8'h8A, e);
    chk8("frozen", d, e);
    @(posedge clock);
    pd <= 1'b0;
    idle(30);
    rd(8'h8A, e);
    chk1("resumed", 1'b1, e !== d);
    $display("test power done");
    conclude;
  end
endmodule // tb_dtc_timer_top
